/* rtl/nvram_cmd_protect.v */
// command decoder, write latch, status register and write protection
//////////////////////////////////////////////////////////////////////
// Behaviour
// - opcode 06h sets write latch, 04h clears it.
// - opcode 05h reads status, 01h writes status.
// - decode 02h write, 03h read, 0Bh fast read; read limited 40 MHz.
// - decode 42h special write, 4Bh special read; special read 40 MHz.
// - fifteen opcodes recognised including 9Fh, 4Ch, C2h, C3h; rest reserved.
// - decode BAh deep sleep and B9h hibernate.
// - latch clear at power-up; master sets latch before any write.
// - latch set only by set command; status write clears it at chip select rise.
// - latch clears at chip select rise ending any write-type command.
// - clear command blocks later writes until latch set again.
// - status bit7 pin enable, bit3 guard high, bit2 guard low, bit1 latch.
// - bits 4,5 read zero, bit 6 reads one, writes to bits 0,4,5,6 ignored.
// - bit 0 reads zero except during wake from sleep or hibernate.
// - guard bits kept nonvolatile across power cycles; reset here clears them to 00.
// - guard 01 protects 30000h up, 10 from 20000h, 11 all.
// - pin enable set and protect pin low blocks status writes.
// - array writes gated only by latch and guard bits.
// - shipped status: stored bits zero, bit 6 one.
// - first byte after chip select falls is opcode.
// - unknown opcode: ignore rest of frame, output stays high impedance.
// - status read shifts out status byte msb first.
// - burst write into guarded block stops address and drops data.
//////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "nvram_cmd_defines.vh"
module nvram_cmd_protect (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // serial pins
    input wire chip_select_n,
    input wire serial_clk,
    input wire serial_in,
    input wire protect_pin_n,
    output reg serial_out,
    output reg serial_out_en,
    // array write port and status
    output reg [17:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_we,
    output reg [7:0] status_view,
    output reg sleep_req,
    output reg wake_busy
);
//////////////////////////////////////////////////////////////////////
localparam S_IDLE = 3'd0;
localparam S_OPCODE = 3'd1;
localparam S_ADDR = 3'd2;
localparam S_DATA = 3'd3;
localparam S_STATUS = 3'd4;
localparam S_IGNORE = 3'd5;
localparam S_PASS = 3'd6;
// stands in for the wake period; wake busy counts it down in system clocks
localparam [7:0] WAKE_CYCLES = 8'h10;

function is_known;
    input [7:0] op;
    begin
        case (op)
            `OP_SET_LATCH, `OP_CLR_LATCH, `OP_STATUS_READ, `OP_STATUS_WRITE,
            `OP_MEM_WRITE, `OP_MEM_READ, `OP_FAST_READ, `OP_SS_WRITE,
            `OP_SS_READ, `OP_DEV_ID_READ, `OP_UID_READ, `OP_SN_WRITE,
            `OP_SN_READ, `OP_DEEP_SLEEP, `OP_HIBERNATE: is_known = 1'b1;
            default: is_known = 1'b0;
        endcase
    end
endfunction

function is_write_op;
    input [7:0] op;
    begin
        is_write_op = (op == `OP_CLR_LATCH) || (op == `OP_STATUS_WRITE) ||
            (op == `OP_MEM_WRITE) || (op == `OP_SS_WRITE) || (op == `OP_SN_WRITE);
    end
endfunction

function guarded;
    input [1:0] g;
    input [17:0] a;
    begin
        case (g)
            2'b01: guarded = (a >= `GUARD_QUARTER);
            2'b10: guarded = (a >= `GUARD_HALF);
            2'b11: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    end
endfunction
//////////////////////////////////////////////////////////////////////
wire [3:0] sync_w;
pin_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({chip_select_n, serial_clk, serial_in, protect_pin_n}),
    .pin_out(sync_w)
);
wire cs_n_s = sync_w[3];
wire sck_s = sync_w[2];
wire si_s = sync_w[1];
wire wp_n_s = sync_w[0];

reg cs_prev_q, sck_prev_q;
reg [2:0] state_q;
reg [7:0] shift_q;
reg [2:0] bit_q;
reg [1:0] addr_cnt_q;
reg [7:0] opcode_q;
reg [17:0] addr_q;
reg stopped_q;
reg latch_q;
reg pin_en_q;
reg [1:0] guard_q;
reg [7:0] tx_q;
reg [7:0] wake_q;
reg armed_q;

wire cs_fall = cs_prev_q & ~cs_n_s;
wire cs_rise = ~cs_prev_q & cs_n_s;
wire sck_rise = ~sck_prev_q & sck_s & ~cs_n_s;
wire sck_fall = sck_prev_q & ~sck_s & ~cs_n_s;
wire [7:0] byte_in = {shift_q[6:0], si_s};
wire byte_done = sck_rise && (bit_q == 3'd7);
wire [7:0] status_w = {pin_en_q, 1'b1, 2'b00, guard_q, latch_q, wake_busy};
wire status_locked = pin_en_q & ~wp_n_s;
//////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
    if (reset) begin
        cs_prev_q <= 1'b1;
        sck_prev_q <= 1'b0;
        state_q <= S_IDLE;
        shift_q <= 8'h00;
        bit_q <= 3'd0;
        addr_cnt_q <= 2'd0;
        opcode_q <= 8'h00;
        addr_q <= 18'h00000;
        stopped_q <= 1'b0;
        latch_q <= 1'b0;
        tx_q <= 8'h00;
        armed_q <= 1'b0;
        serial_out <= 1'b0;
        serial_out_en <= 1'b0;
        mem_addr <= 18'h00000;
        mem_wdata <= 8'h00;
        mem_we <= 1'b0;
        sleep_req <= 1'b0;
    end else begin
        cs_prev_q <= cs_n_s;
        sck_prev_q <= sck_s;
        mem_we <= 1'b0;
        if (sck_rise) begin
            shift_q <= byte_in;
            bit_q <= bit_q + 3'd1;
        end
        if (cs_fall) begin
            state_q <= S_OPCODE;
            bit_q <= 3'd0;
            stopped_q <= 1'b0;
            armed_q <= 1'b0;
            sleep_req <= 1'b0;
        end else if (cs_rise) begin
            // latch clears only at frame end, so a write mid-frame keeps it
            if (armed_q) begin
                latch_q <= 1'b0;
            end
            state_q <= S_IDLE;
            serial_out_en <= 1'b0;
        end else begin
            case (state_q)
                S_OPCODE: begin
                    if (byte_done) begin
                        opcode_q <= byte_in;
                        addr_cnt_q <= 2'd0;
                        if (!is_known(byte_in)) begin
                            state_q <= S_IGNORE;
                        end else begin
                            if (is_write_op(byte_in)) begin
                                armed_q <= 1'b1;
                            end
                            case (byte_in)
                                `OP_SET_LATCH: begin
                                    latch_q <= 1'b1;
                                    state_q <= S_PASS;
                                end
                                `OP_STATUS_READ: begin
                                    tx_q <= status_w;
                                    state_q <= S_STATUS;
                                end
                                `OP_STATUS_WRITE: state_q <= S_DATA;
                                `OP_MEM_WRITE: state_q <= S_ADDR;
                                `OP_DEEP_SLEEP, `OP_HIBERNATE: begin
                                    sleep_req <= 1'b1;
                                    state_q <= S_PASS;
                                end
                                // other data phases belong to neighbouring blocks
                                default: state_q <= S_PASS;
                            endcase
                        end
                    end
                end
                S_ADDR: begin
                    if (byte_done) begin
                        addr_q <= {addr_q[9:0], byte_in};
                        addr_cnt_q <= addr_cnt_q + 2'd1;
                        if (addr_cnt_q == 2'd2) begin
                            state_q <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (byte_done && opcode_q == `OP_STATUS_WRITE) begin
                        // the stored fields take the byte in their own process
                        state_q <= S_PASS;
                    end else if (byte_done && latch_q && !stopped_q) begin
                        if (guarded(guard_q, addr_q)) begin
                            stopped_q <= 1'b1;
                        end else begin
                            mem_addr <= addr_q;
                            mem_wdata <= byte_in;
                            mem_we <= 1'b1;
                            addr_q <= addr_q + 18'h00001;
                        end
                    end
                end
                S_STATUS: begin
                    if (sck_fall) begin
                        serial_out_en <= 1'b1;
                        serial_out <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                S_IGNORE: serial_out_en <= 1'b0;
                default: ;
            endcase
        end
    end
end
//////////////////////////////////////////////////////////////////////
// stored fields; guard bits are cleared by reset and loaded by a status write here, the
// nonvolatile copy is held outside this block
reg st_wr_q;
reg [7:0] st_data_q;
always @(posedge sys_clk) begin
    if (reset) begin
        pin_en_q <= `ST_PIN_EN_RST;
        guard_q <= `ST_GUARD_RST;
    end else if (st_wr_q) begin
        pin_en_q <= st_data_q[`ST_PIN_EN];
        guard_q <= st_data_q[`ST_GUARD_HI:`ST_GUARD_LO];
    end
end
always @(posedge sys_clk) begin
    if (reset) begin
        st_wr_q <= 1'b0;
        st_data_q <= 8'h00;
    end else begin
        // refused while the latch is clear or the pin lock holds
        st_wr_q <= (state_q == S_DATA) && byte_done && (opcode_q == `OP_STATUS_WRITE) &&
            latch_q && !status_locked && !cs_fall;
        st_data_q <= byte_in;
    end
end
//////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
    if (reset) begin
        wake_q <= 8'h00;
        wake_busy <= 1'b0;
        status_view <= 8'h40;
    end else begin
        if (cs_fall && sleep_req) begin
            wake_q <= WAKE_CYCLES;
        end else if (wake_q != 8'h00) begin
            wake_q <= wake_q - 8'h01;
        end
        wake_busy <= (wake_q != 8'h00);
        status_view <= status_w;
    end
end
endmodule // nvram_cmd_protect

/* pkg/nvram_cmd_defines.vh */
// constants for the serial command interpreter and its protection logic
`ifndef NVRAM_CMD_DEFINES_VH
`define NVRAM_CMD_DEFINES_VH

// opcodes
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_WRITE 8'h02
`define OP_MEM_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_SS_WRITE 8'h42
`define OP_SS_READ 8'h4B
`define OP_DEV_ID_READ 8'h9F
`define OP_UID_READ 8'h4C
`define OP_SN_WRITE 8'hC2
`define OP_SN_READ 8'hC3
`define OP_DEEP_SLEEP 8'hBA
`define OP_HIBERNATE 8'hB9

// status register field positions
`define ST_PIN_EN 7
`define ST_ONE 6
`define ST_GUARD_HI 3
`define ST_GUARD_LO 2
`define ST_LATCH 1
`define ST_BUSY 0

// shipped values of the stored fields
`define ST_PIN_EN_RST 1'b0
`define ST_GUARD_RST 2'h0

// guarded block limits
`define GUARD_QUARTER 18'h30000
`define GUARD_HALF 18'h20000

`endif

/* rtl/pin_sync.v */
// two flop synchroniser for the asynchronous serial pins
`timescale 1ns/100ps
module pin_sync (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // pins and synchronised levels
    input wire [3:0] pin_in,
    output reg [3:0] pin_out
);
reg [3:0] meta_q;
always @(posedge sys_clk) begin
    if (reset) begin
        meta_q <= 4'hF;
        pin_out <= 4'hF;
    end else begin
        meta_q <= pin_in;
        pin_out <= meta_q;
    end
end
endmodule // pin_sync

/* bench/spi_master_model.sv */
// serial master model driving the pins in mode 0
`timescale 1ns/100ps
module spi_master_model #(
    parameter real HALF_NS = 62.5,
    parameter integer POWER_UP_WAIT_NS = 200
) (
    // serial pins
    output reg chip_select_n,
    output reg serial_clk,
    output reg serial_in,
    input wire serial_out,
    input wire serial_out_en
);
    reg ready;
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        ready = 1'b0;
        #(POWER_UP_WAIT_NS) ready = 1'b1;
    end
    task cs_lo;
        begin
            wait (ready);
            chip_select_n = 1'b0;
            #(HALF_NS);
        end
    endtask
    // clock stands low outside frames; 8 MHz stays under every limit
    task xbyte(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                serial_in = tx[i];
                #(HALF_NS) serial_clk = 1'b1;
                rx[i] = serial_out_en ? serial_out : 1'b1;
                #(HALF_NS) serial_clk = 1'b0;
            end
        end
    endtask
    // released input shows the inverse of its last bit
    task cs_hi;
        begin
            #(HALF_NS) chip_select_n = 1'b1;
            serial_in = ~serial_in;
            #(HALF_NS * 2);
        end
    endtask
endmodule // spi_master_model

/* bench/nvram_cmd_protect_sva.sv */
// assertions on the command and protection block ports
`timescale 1ns/100ps
`include "nvram_cmd_defines.vh"
module nvram_cmd_protect_sva (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    // watched ports
    input wire chip_select_n,
    input wire protect_pin_n,
    input wire serial_out_en,
    input wire [17:0] mem_addr,
    input wire mem_we,
    input wire [7:0] status_view,
    input wire sleep_req,
    input wire wake_busy
);
    wire [1:0] g = status_view[3:2];
    wire guarded = (g == 2'h3) || (g == 2'h2 && mem_addr >= `GUARD_HALF)
        || (g == 2'h1 && mem_addr >= `GUARD_QUARTER);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    //////////////////////////////////////////////////////////////////
    a_busy_bit: assert property (status_view[0] == $past(wake_busy))
        else $error("status bit 0 differs from wake flag");
    a_fixed_bits: assert property (status_view[6:4] == 3'h4)
        else $error("fixed status bits wrong");
    a_we_latch: assert property (mem_we |-> status_view[1])
        else $error("array write with latch clear");
    a_we_guard: assert property (mem_we |-> !guarded)
        else $error("array write into guarded block");
    a_we_pulse: assert property ($rose(mem_we) |=> !mem_we)
        else $error("write strobe longer than one cycle");
    a_latch_fall: assert property ($fell(status_view[1]) |->
        chip_select_n && !$past(chip_select_n, 8))
        else $error("latch cleared away from frame end");
    a_idle_tristate: assert property (chip_select_n [*8] |-> !serial_out_en)
        else $error("output driven while deselected");
    a_status_guard: assert property ($changed(status_view[7:2]) |->
        $past(status_view[1]) && ($past(protect_pin_n) || !$past(status_view[7])))
        else $error("status changed while protected");
    a_sleep_hold: assert property (sleep_req && chip_select_n |=> sleep_req)
        else $error("sleep request dropped outside a frame");
    c_write: cover property (mem_we);
    c_latch_clear: cover property ($fell(status_view[1]));
    c_drive: cover property (serial_out_en);
endmodule // nvram_cmd_protect_sva
bind nvram_cmd_protect nvram_cmd_protect_sva nvram_cmd_protect_sva_i (
    .sys_clk(sys_clk), .reset(reset), .chip_select_n(chip_select_n),
    .protect_pin_n(protect_pin_n), .serial_out_en(serial_out_en),
    .mem_addr(mem_addr), .mem_we(mem_we), .status_view(status_view),
    .sleep_req(sleep_req), .wake_busy(wake_busy));

/* bench/testbench.sv */
// self-checking bench for the command and protection block
`timescale 1ns/100ps
`include "nvram_cmd_defines.vh"
module testbench;
    reg sys_clk = 1'b0;
    reg reset = 1'b1;
    reg protect_pin_n = 1'b1;
    wire cs_n, sck, sdi, sdo, sdo_en, mem_we, sleep_req, wake_busy;
    wire [17:0] mem_addr;
    wire [7:0] mem_wdata, status_view;
    integer n_fail = 0;
    integer check_count = 0;
    integer n_we = 0;
    reg [17:0] we_addr;
    reg [7:0] we_data;
    reg en_seen = 1'b0;
    reg [7:0] rx;
    // opcode and status expected after a latch set and that frame
    function [15:0] ops_at(input integer i);
        begin
            case (i)
                0: ops_at = 16'h0042;
                1: ops_at = 16'hFF42;
                2: ops_at = 16'hA742;
                3: ops_at = 16'h0642;
                4: ops_at = 16'h0542;
                5: ops_at = 16'h0342;
                6: ops_at = 16'h0B42;
                7: ops_at = 16'h4B42;
                8: ops_at = 16'h9F42;
                9: ops_at = 16'h4C42;
                10: ops_at = 16'hC342;
                11: ops_at = 16'h0440;
                12: ops_at = 16'h0140;
                13: ops_at = 16'h0240;
                14: ops_at = 16'h4240;
                default: ops_at = 16'hC240;
            endcase
        end
    endfunction
    always #4 sys_clk = ~sys_clk;
    nvram_cmd_protect nvram_cmd_protect_i (.sys_clk(sys_clk), .reset(reset),
        .chip_select_n(cs_n), .serial_clk(sck), .serial_in(sdi),
        .protect_pin_n(protect_pin_n), .serial_out(sdo), .serial_out_en(sdo_en),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .status_view(status_view), .sleep_req(sleep_req), .wake_busy(wake_busy));
    spi_master_model spi_master_model_i (.chip_select_n(cs_n), .serial_clk(sck),
        .serial_in(sdi), .serial_out(sdo), .serial_out_en(sdo_en));
    always @(posedge sys_clk) begin
        if (mem_we === 1'b1) begin
            n_we <= n_we + 1;
            we_addr <= mem_addr;
            we_data <= mem_wdata;
        end
        if (sdo_en === 1'b1) en_seen <= 1'b1;
    end
    //////////////////////////////////////////////////////////////////
    task end_of_test;
        begin
            $display("checks %0d, mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [95:0] what, input [31:0] exp, input [31:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    // tail bytes go out from the top, msb first
    task frame(input [7:0] op, input [39:0] tail, input integer n);
        integer k;
        begin
            spi_master_model_i.cs_lo;
            spi_master_model_i.xbyte(op, rx);
            for (k = 0; k < n; k = k + 1)
                spi_master_model_i.xbyte(tail[39-8*k -: 8], rx);
            spi_master_model_i.cs_hi;
        end
    endtask
    task rd_st(input [7:0] exp);
        begin
            frame(`OP_STATUS_READ, 40'h0, 1);
            chk("status", exp, rx);
        end
    endtask
    task wst(input [7:0] v);
        begin
            frame(`OP_SET_LATCH, 40'h0, 0);
            frame(`OP_STATUS_WRITE, {v, 32'h0}, 1);
        end
    endtask
    //////////////////////////////////////////////////////////////////
    task t_ops;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                frame(`OP_SET_LATCH, 40'h0, 0);
                en_seen = 1'b0;
                frame(ops_at(i) >> 8, 40'h0, 4);
                if (i < 3) chk("out_en", 0, en_seen);
                rd_st(ops_at(i) & 16'h00FF);
            end
        end
    endtask
    task t_status;
        begin
            frame(`OP_SET_LATCH, 40'h0, 0);
            frame(`OP_CLR_LATCH, 40'h0, 0);
            frame(`OP_STATUS_WRITE, 40'hFF00000000, 1);
            rd_st(8'h40);
            wst(8'hFF);
            rd_st(8'hCC);
            @(posedge sys_clk) protect_pin_n <= 1'b0;
            wst(8'h00);
            rd_st(8'hCC);
            @(posedge sys_clk) protect_pin_n <= 1'b1;
            wst(8'h04);
            rd_st(8'h44);
        end
    endtask
    // guard 01 leaves 2FFFFh open and closes 30000h
    task t_mem;
        integer n0;
        begin
            n0 = n_we;
            frame(`OP_SET_LATCH, 40'h0, 0);
            frame(`OP_MEM_WRITE, 40'h02FFFFA55A, 5);
            chk("we_count", n0 + 1, n_we);
            chk("we_addr", 18'h2FFFF, we_addr);
            chk("we_data", 8'hA5, we_data);
            frame(`OP_MEM_WRITE, 40'h0000003C00, 4);
            chk("we_count", n0 + 1, n_we);
        end
    endtask
    task t_sleep;
        begin
            frame(`OP_DEEP_SLEEP, 40'h0, 0);
            chk("sleep", 1, sleep_req);
            frame(`OP_HIBERNATE, 40'h0, 0);
            chk("sleep", 1, sleep_req);
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd_st(8'h40);
        t_ops;
        t_status;
        t_mem;
        t_sleep;
        end_of_test;
    end
    // under a fifth of a millisecond of traffic is expected
    initial begin
        #600000;
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule // testbench
